// file: verilog/pd_msg_pkg.sv
// Package for the PD message buffer register block.
// Assumes byte-wide register access from a decoded register port.
package pd_msg_pkg;
  localparam logic [7:0] rx_count_addr   = 8'h30;
  localparam logic [7:0] rx_kind_addr    = 8'h31;
  localparam logic [7:0] rx_hdr_lo_addr  = 8'h32;
  localparam logic [7:0] rx_hdr_hi_addr  = 8'h33;
  localparam logic [7:0] rx_obj_first    = 8'h34;
  localparam logic [7:0] rx_obj_last     = 8'h4f;
  localparam logic [7:0] rx_detect_addr  = 8'h2f;
  localparam logic [7:0] tx_cmd_addr     = 8'h50;
  localparam logic [7:0] tx_count_addr   = 8'h51;
  localparam logic [7:0] tx_hdr_lo_addr  = 8'h52;
  localparam logic [7:0] tx_hdr_hi_addr  = 8'h53;
  localparam logic [7:0] reg_reset_value = 8'h00;
  localparam logic [7:0] rx_count_extra  = 8'h03;
  localparam logic [7:0] tx_cmd_used     = 8'h37;
  localparam logic [7:0] rx_detect_used  = 8'h7f;
  localparam int         obj_bytes       = 28;
  localparam int         kind_hard_reset = 5;
  localparam int         kind_cable_rst  = 6;
  localparam logic [2:0] kind_cable_code = 3'h6;

  // One received byte on its way from the line engine.
  typedef struct packed {
    logic       first;
    logic       last;
    logic [2:0] kind;
    logic [7:0] data;
  } rx_beat_s;

  // A register bus access.
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;
endpackage

// file: verilog/pd_byte_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
module pd_byte_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,     // System clock.
  input  wire logic             rst,       // Synchronous reset.
  input  wire logic [WIDTH-1:0] in_data,   // Write data.
  input  wire logic             in_valid,  // Write request.
  output logic                  in_ready,  // Room available.
  output logic      [WIDTH-1:0] out_data,  // Head of queue.
  output logic                  out_valid, // Queue not empty.
  input  wire logic             out_ready  // Reader takes head.
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be 2^n");
  end
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wptr_reg;
  logic [AW:0]      rptr_reg;
  logic             push;
  logic             pop;

  // Full when pointers differ only in the wrap bit.
  assign in_ready  = !(wptr_reg[AW] != rptr_reg[AW] &&
                       wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);
  assign out_valid = wptr_reg != rptr_reg;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_reg[rptr_reg[AW-1:0]];

  // Storage is written without reset; only pointers need a defined value.
  always_ff @(posedge clock) begin
    if (push) begin
      mem_reg[wptr_reg[AW-1:0]] <= in_data;
    end
  end

  // Pointer update.
  always_ff @(posedge clock) begin
    if (rst) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else begin
      if (push) wptr_reg <= wptr_reg + 1'b1;
      if (pop) rptr_reg <= rptr_reg + 1'b1;
    end
  end
endmodule

// file: verilog/pd_obj_ram.sv
// Receive data-object byte store with registered read data.
// Assumes one clock; contents are cleared lazily by the byte count.
module pd_obj_ram #(
  parameter int DEPTH = 28
) (
  input  wire logic       clock,  // System clock.
  input  wire logic       we,     // Write strobe.
  input  wire logic [4:0] waddr,  // Write index.
  input  wire logic [7:0] wdata,  // Write byte.
  input  wire logic [4:0] raddr,  // Read index.
  output logic      [7:0] rdata   // Registered read byte.
);
  initial begin
    if (DEPTH > 32) $error("DEPTH exceeds index width");
  end
  logic [7:0] mem_reg [DEPTH];

  // Byte store; read is one cycle late so it maps onto block memory.
  always_ff @(posedge clock) begin
    if (we && int'(waddr) < DEPTH) mem_reg[waddr] <= wdata;
    rdata <= (int'(raddr) < DEPTH) ? mem_reg[raddr] : 8'h00;
  end
endmodule

// file: verilog/pd_message_buffer_regs.sv
// Receive and transmit message buffer registers of a PD physical layer.
// Assumes a byte register port from the interface decoder and a message
// engine that streams received bytes and reports transmit completion.

// Overview of operation
// - Hard Reset or disconnect zeroes receive count unless a message completes that cycle.
// - Clearing received flag zeroes receive count.
// - Receive count is object bytes plus three.
// - Frame kind reports start-of-packet code.
// - Received header as two read-only bytes.
// - Received objects readable across 0x34-0x4f.
// - Count and kind adjacent, reset zero.
// - Transmit end clears command and count.
// - Retry field gives retransmissions zero to three.
// - Transmit type selects kind of transmission.
// - Transmit header held in two writable bytes.
// - Reserved command bits are ignored.
// - Accept only enabled kinds; Hard Reset clears.
module pd_message_buffer_regs #(
  parameter int OBJ_BYTES  = pd_msg_pkg::obj_bytes,
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic                 clock,         // 250 MHz clock.
  input  wire logic                 rst,           // Sync reset.
  input  wire pd_msg_pkg::reg_req_s reg_req,       // Register access.
  input  wire logic                 reg_valid,     // Access strobe.
  output logic               [7:0]  reg_rdata,     // Read data.
  output logic                      reg_rvalid,    // Read data valid.
  input  wire logic                 flag_clear,    // Status flag cleared.
  input  wire logic                 disconnect,    // Detach pulse.
  input  wire logic                 hard_rst_seen, // Hard Reset in/out.
  input  wire pd_msg_pkg::rx_beat_s rx_beat,       // Received byte.
  input  wire logic                 rx_valid,      // Byte present.
  output logic                      rx_ready,      // Room in FIFO.
  output logic                      message_received_flag, // New msg.
  output logic                      tx_start,      // Start pulse.
  output logic               [2:0]  outgoing_frame_kind, // Type.
  output logic               [1:0]  tx_retries,    // Retry count.
  output logic               [7:0]  tx_count_out,  // Byte count.
  output logic              [15:0]  tx_header_out, // Header word.
  input  wire logic                 tx_done        // Send finished.
);
  initial begin
    if (OBJ_BYTES != 28) $error("object window is fixed at 28 bytes");
    if (FIFO_DEPTH < 2) $error("FIFO too shallow");
  end

  localparam int BW = $bits(pd_msg_pkg::rx_beat_s);

  logic [7:0]  rx_count_reg;
  logic [2:0]  rx_kind_reg;
  logic [7:0]  hdr_lo_reg;
  logic [7:0]  hdr_hi_reg;
  logic [7:0]  rx_detect_reg;
  logic [7:0]  tx_cmd_reg;
  logic [7:0]  tx_count_reg;
  logic [7:0]  tx_hdr_lo_reg;
  logic [7:0]  tx_hdr_hi_reg;
  logic [7:0]  wr_idx_reg;
  logic        drop_reg;
  logic [7:0]  rd_addr_reg;
  logic        rd_pend_reg;
  logic [BW-1:0]        fifo_out;
  pd_msg_pkg::rx_beat_s beat;
  logic        beat_valid;
  logic        beat_take;
  logic        wr_en;
  logic        obj_we;
  logic [4:0]  obj_waddr;
  logic [4:0]  obj_raddr;
  logic [7:0]  obj_rdata;
  logic        obj_live;

  // True when the start-of-packet kind is enabled in the detect register.
  function automatic logic kind_enabled(input logic [2:0] k,
                                        input logic [7:0] en);
    if (int'(k) == pd_msg_pkg::kind_cable_rst) return en[6];
    if (int'(k) < pd_msg_pkg::kind_hard_reset) return en[k];
    return 1'b0;
  endfunction

  // True when an address falls inside the object window.
  function automatic logic in_obj(input logic [7:0] a);
    return a >= pd_msg_pkg::rx_obj_first && a <= pd_msg_pkg::rx_obj_last;
  endfunction

  // The FIFO decouples the line engine; a stalled drain back-pressures it.
  pd_byte_fifo #(.WIDTH(BW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_data   (rx_beat),
    .in_valid  (rx_valid),
    .in_ready  (rx_ready),
    .out_data  (fifo_out),
    .out_valid (beat_valid),
    .out_ready (beat_take)
  );

  assign beat = pd_msg_pkg::rx_beat_s'(fifo_out);
  // Drain stalls while a message waits for the processor to take it.
  assign beat_take = beat_valid && !message_received_flag;
  assign wr_en = reg_valid && reg_req.wr;

  // object byte store
  // Bytes past the window are dropped rather than wrapping onto byte 0.
  assign obj_we    = beat_take && !drop_reg && !beat.first &&
                     wr_idx_reg >= 8'h02 &&
                     wr_idx_reg < 8'(OBJ_BYTES) + 8'h02;
  assign obj_waddr = 5'(wr_idx_reg - 8'h02);
  assign obj_raddr = 5'(reg_req.addr - pd_msg_pkg::rx_obj_first);

  pd_obj_ram #(.DEPTH(OBJ_BYTES)) u_ram (
    .clock (clock),
    .we    (obj_we),
    .waddr (obj_waddr),
    .wdata (beat.data),
    .raddr (obj_raddr),
    .rdata (obj_rdata)
  );

  // Assembly of an incoming message; first beat carries header low.
  always_ff @(posedge clock) begin
    if (rst) begin
      wr_idx_reg <= 8'h00;
      drop_reg   <= 1'b0;
    end else if (beat_take) begin
      if (beat.first) begin
        drop_reg   <= !kind_enabled(beat.kind, rx_detect_reg);
        wr_idx_reg <= 8'h01;
      end else begin
        wr_idx_reg <= wr_idx_reg + 8'h01;
      end
    end
  end

  // Header and frame kind capture.
  always_ff @(posedge clock) begin
    if (rst) begin
      rx_kind_reg <= 3'h0;
      hdr_lo_reg  <= pd_msg_pkg::reg_reset_value;
      hdr_hi_reg  <= pd_msg_pkg::reg_reset_value;
    end else if (beat_take) begin
      if (beat.first && kind_enabled(beat.kind, rx_detect_reg)) begin
        hdr_lo_reg  <= beat.data;
        rx_kind_reg <= beat.kind;
      end else if (!beat.first && !drop_reg && wr_idx_reg == 8'h01) begin
        hdr_hi_reg <= beat.data;
      end
    end
  end

  // Receive byte count and received-message flag.
  always_ff @(posedge clock) begin
    if (rst) begin
      rx_count_reg          <= pd_msg_pkg::reg_reset_value;
      message_received_flag <= 1'b0;
    end else if (beat_take && beat.last && !drop_reg && !beat.first) begin
      // last beat index plus one, plus one kind byte
      rx_count_reg          <= wr_idx_reg + 8'h02;
      message_received_flag <= 1'b1;
    end else if (hard_rst_seen || disconnect) begin
      rx_count_reg          <= pd_msg_pkg::reg_reset_value;
      message_received_flag <= 1'b0;
    end else if (flag_clear) begin
      rx_count_reg          <= pd_msg_pkg::reg_reset_value;
      message_received_flag <= 1'b0;
    end
  end

  // Receive-detect enables.
  always_ff @(posedge clock) begin
    if (rst) begin
      rx_detect_reg <= pd_msg_pkg::reg_reset_value;
    end else if (hard_rst_seen) begin
      rx_detect_reg <= pd_msg_pkg::reg_reset_value;
    end else if (wr_en && reg_req.addr == pd_msg_pkg::rx_detect_addr) begin
      rx_detect_reg <= reg_req.wdata & pd_msg_pkg::rx_detect_used;
    end
  end

  // Transmit command and byte count.
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_cmd_reg   <= pd_msg_pkg::reg_reset_value;
      tx_count_reg <= pd_msg_pkg::reg_reset_value;
    end else if (tx_done) begin
      tx_cmd_reg   <= pd_msg_pkg::reg_reset_value;
      tx_count_reg <= pd_msg_pkg::reg_reset_value;
    end else if (wr_en) begin
      if (reg_req.addr == pd_msg_pkg::tx_cmd_addr) begin
        tx_cmd_reg <= reg_req.wdata;
      end
      if (reg_req.addr == pd_msg_pkg::tx_count_addr) begin
        tx_count_reg <= reg_req.wdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tx_hdr_lo_reg <= pd_msg_pkg::reg_reset_value;
      tx_hdr_hi_reg <= pd_msg_pkg::reg_reset_value;
    end else if (wr_en) begin
      if (reg_req.addr == pd_msg_pkg::tx_hdr_lo_addr) begin
        tx_hdr_lo_reg <= reg_req.wdata;
      end
      if (reg_req.addr == pd_msg_pkg::tx_hdr_hi_addr) begin
        tx_hdr_hi_reg <= reg_req.wdata;
      end
    end
  end

  // Transmit hand-off to the message engine.
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_start            <= 1'b0;
      outgoing_frame_kind <= 3'h0;
      tx_retries          <= 2'h0;
      tx_count_out        <= 8'h00;
      tx_header_out       <= 16'h0000;
    end else begin
      tx_start <= wr_en && reg_req.addr == pd_msg_pkg::tx_cmd_addr;
      if (wr_en && reg_req.addr == pd_msg_pkg::tx_cmd_addr) begin
        outgoing_frame_kind <= reg_req.wdata[2:0];
        tx_retries          <= reg_req.wdata[5:4];
        tx_count_out        <= tx_count_reg;
        tx_header_out       <= {tx_hdr_hi_reg, tx_hdr_lo_reg};
      end
    end
  end

  // Read address is held one cycle to line up with the object store.
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_addr_reg <= 8'h00;
      rd_pend_reg <= 1'b0;
    end else begin
      rd_addr_reg <= reg_req.addr;
      rd_pend_reg <= reg_valid && !reg_req.wr;
    end
  end

  // counted object bytes only
  // Bytes past the count read zero, so the unreset store never leaks.
  assign obj_live = (rd_addr_reg - pd_msg_pkg::rx_obj_first) +
                    pd_msg_pkg::rx_count_extra < rx_count_reg;

  // Read data mux; unmapped addresses read zero.
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= rd_pend_reg;
      reg_rdata  <= 8'h00;
      if (rd_pend_reg) begin
        unique case (rd_addr_reg)
          pd_msg_pkg::rx_count_addr:  reg_rdata <= rx_count_reg;
          pd_msg_pkg::rx_kind_addr:   reg_rdata <= {5'h00, rx_kind_reg};
          pd_msg_pkg::rx_hdr_lo_addr: reg_rdata <= hdr_lo_reg;
          pd_msg_pkg::rx_hdr_hi_addr: reg_rdata <= hdr_hi_reg;
          pd_msg_pkg::rx_detect_addr: reg_rdata <= rx_detect_reg;
          // reserved bits read back as zero
          pd_msg_pkg::tx_cmd_addr:
            reg_rdata <= tx_cmd_reg & pd_msg_pkg::tx_cmd_used;
          pd_msg_pkg::tx_count_addr:  reg_rdata <= tx_count_reg;
          pd_msg_pkg::tx_hdr_lo_addr: reg_rdata <= tx_hdr_lo_reg;
          pd_msg_pkg::tx_hdr_hi_addr: reg_rdata <= tx_hdr_hi_reg;
          default: begin
            if (in_obj(rd_addr_reg) && obj_live) reg_rdata <= obj_rdata;
          end
        endcase
      end
    end
  end

  // A command write with none right behind it; a second one restarts.
  sequence lone_cmd_write_s;
    (wr_en && reg_req.addr == pd_msg_pkg::tx_cmd_addr) ##1
      !(wr_en && reg_req.addr == pd_msg_pkg::tx_cmd_addr);
  endsequence

  // The start pulse stands for exactly one cycle.
  sequence start_pulse_s;
    tx_start ##1 !tx_start;
  endsequence

  AST_TX_CLEAR: assert property (@(posedge clock)
    disable iff (rst)
    tx_done |=> tx_cmd_reg == 8'h00 && tx_count_reg == 8'h00)
    else $error("transmit registers not cleared");
  AST_RX_CLEAR: assert property (@(posedge clock)
    disable iff (rst)
    (disconnect && !(beat_take && beat.last)) |=> rx_count_reg == 8'h00)
    else $error("receive count survived detach");
  AST_FLAG_CLEAR: assert property (@(posedge clock)
    disable iff (rst)
    (flag_clear && !beat_take) |=> rx_count_reg == 8'h00)
    else $error("receive count survived flag clear");
  AST_DETECT_CLEAR: assert property (@(posedge clock)
    disable iff (rst)
    hard_rst_seen |=> rx_detect_reg == 8'h00)
    else $error("detect enables survived hard reset");
  AST_COUNT_MIN: assert property (@(posedge clock)
    disable iff (rst)
    $rose(message_received_flag) |->
      rx_count_reg >= pd_msg_pkg::rx_count_extra)
    else $error("receive count below header size");
  AST_START: assert property (@(posedge clock)
    disable iff (rst)
    lone_cmd_write_s |-> start_pulse_s)
    else $error("start pulse wrong");
  AST_RETRY: assert property (@(posedge clock)
    disable iff (rst)
    tx_start |-> tx_retries == $past(reg_req.wdata[5:4]))
    else $error("retry field mismatch");
  AST_KIND: assert property (@(posedge clock)
    disable iff (rst)
    tx_start |-> outgoing_frame_kind == $past(reg_req.wdata[2:0]))
    else $error("transmit type mismatch");
endmodule

// file: bench/pd_engine_model.sv
// Stand-in for the PD line engine on the far side of the buffer block.
// Assumes the bench calls send and that the engine moves on falling edges.
module pd_engine_model #(
  parameter int DONE_GAP = 20
) (
  input  wire logic            clock,    // System clock.
  input  wire logic            tx_start, // Start pulse from the block.
  input  wire logic            rx_ready, // Room in the receive FIFO.
  output pd_msg_pkg::rx_beat_s rx_beat,  // Received byte.
  output logic                 rx_valid, // Byte present.
  output logic                 tx_done   // Send finished.
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet lines at time zero.
  initial begin
    rx_beat = '0;
    rx_valid = 1'b0;
    tx_done = 1'b0;
  end

  // Each start ends after a fixed gap, long enough for a readback first.
  always @(posedge clock) begin
    if (tx_start === 1'b1) begin
      repeat (DONE_GAP) @(negedge clock);
      tx_done = 1'b1;
      @(negedge clock);
      tx_done = 1'b0;
    end
  end

  // Streams n beats: header low, header high, then object bytes.
  task automatic send(input logic [2:0] k, input logic [7:0] base,
                      input int n);
    int   t;
    logic ok;
    for (int i = 0; i < n; i++) begin
      @(negedge clock);
      rx_beat = '{i == 0, i == n - 1, k, base + 8'(i)};
      rx_valid = 1'b1;
      t = 0;
      // Ready is taken before the edge, as the block itself sees it.
      do begin
        ok = (rx_ready === 1'b1);
        @(posedge clock);
        t++;
      end while (!ok && t < 50);
    end
    @(negedge clock);
    rx_valid = 1'b0;
    // A released line must not keep showing the last byte.
    rx_beat = ~rx_beat;
  endtask
endmodule

// file: bench/testbench.sv
// Self-checking bench for the PD message buffer register block.
// Assumes the line engine model answers transmit starts on its own.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clock = 1'b0;
  logic                 rst = 1'b1;
  pd_msg_pkg::reg_req_s reg_req = '0;
  logic                 reg_valid = 1'b0;
  logic [7:0]           reg_rdata;
  logic                 reg_rvalid;
  logic                 flag_clear = 1'b0;
  logic                 disconnect = 1'b0;
  logic                 hard_rst_seen = 1'b0;
  pd_msg_pkg::rx_beat_s rx_beat;
  logic                 rx_valid, rx_ready, message_received_flag;
  logic                 tx_start, tx_done;
  logic [2:0]           outgoing_frame_kind;
  logic [1:0]           tx_retries;
  logic [7:0]           tx_count_out;
  logic [15:0]          tx_header_out;
  int                   mismatches = 0;
  int                   comparisons = 0;

  // Clock of 4 ns period.
  always #2 clock = ~clock;

  pd_message_buffer_regs DUT (.clock(clock), .rst(rst), .reg_req(reg_req),
    .reg_valid(reg_valid), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .flag_clear(flag_clear), .disconnect(disconnect),
    .hard_rst_seen(hard_rst_seen), .rx_beat(rx_beat), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .message_received_flag(message_received_flag),
    .tx_start(tx_start), .outgoing_frame_kind(outgoing_frame_kind),
    .tx_retries(tx_retries), .tx_count_out(tx_count_out),
    .tx_header_out(tx_header_out), .tx_done(tx_done));

  pd_engine_model partner (.clock(clock), .tx_start(tx_start),
    .rx_ready(rx_ready), .rx_beat(rx_beat), .rx_valid(rx_valid),
    .tx_done(tx_done));

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits on a handshake flag; running out of time ends the run.
  task automatic await(ref logic s, input int lim);
    int t;
    t = 0;
    while (s !== 1'b1 && t < lim) begin
      @(posedge clock);
      #1;
      t++;
    end
    if (s !== 1'b1) begin
      check(16'h0dea, 16'h0000);
      conclude();
    end
  endtask

  // One register access; a read returns its answer one cycle after the edge that takes it.
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(negedge clock);
    reg_req = '{w, a, d};
    reg_valid = 1'b1;
    @(negedge clock);
    reg_valid = 1'b0;
    q = 8'h00;
    if (w == 1'b0) begin
      await(reg_rvalid, 6);
      q = reg_rdata;
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    check(q, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic pulse(ref logic s);
    @(negedge clock);
    s = 1'b1;
    @(negedge clock);
    s = 1'b0;
  endtask

  // Every buffer register comes out of reset as zero.
  task automatic reset_values();
    logic [7:0] a[12] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h4f, 8'h50,
                          8'h51, 8'h52, 8'h53, 8'h2f, 8'h80};
    foreach (a[i]) rd(a[i], 8'h00);
  endtask

  // Each received kind, with object counts up to the full 28 bytes.
  task automatic rx_kinds();
    logic [2:0] k[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
    int         n[6] = '{0, 1, 4, 5, 8, 28};
    logic [7:0] b;
    wr(8'h2f, 8'h7f);
    for (int i = 0; i < 6; i++) begin
      b = 8'h40 + 8'(i * 16);
      partner.send(k[i], b, n[i] + 2);
      await(message_received_flag, 200);
      rd(8'h30, 8'(n[i] + 3));
      rd(8'h31, 8'(k[i]));
      rd(8'h32, b);
      rd(8'h33, b + 8'h01);
      if (n[i] > 0) rd(8'h34 + 8'(n[i] - 1), b + 8'(n[i] + 1));
      wr(8'h31, 8'hff);
      rd(8'h31, 8'(k[i]));
      pulse(flag_clear);
      rd(8'h30, 8'h00);
      check(message_received_flag, 1'b0);
    end
  endtask

  // Disabled kinds are dropped; resets clear the count.
  task automatic rx_resets();
    wr(8'h2f, 8'h01);
    partner.send(3'h1, 8'h11, 3);
    repeat (40) @(negedge clock);
    check(message_received_flag, 1'b0);
    rd(8'h30, 8'h00);
    rd(8'h32, 8'h90);
    partner.send(3'h0, 8'h20, 3);
    await(message_received_flag, 200);
    pulse(hard_rst_seen);
    rd(8'h30, 8'h00);
    rd(8'h2f, 8'h00);
    wr(8'h2f, 8'h01);
    partner.send(3'h0, 8'h30, 2);
    await(message_received_flag, 200);
    // A held message stalls the drain until the FIFO pushes back.
    fork
      partner.send(3'h0, 8'h60, 17);
    join_none
    repeat (24) @(negedge clock);
    check(rx_ready, 1'b0);
    rd(8'h30, 8'h03);
    pulse(disconnect);
    rd(8'h30, 8'h00);
    rd(8'h2f, 8'h01);
    await(message_received_flag, 200);
    rd(8'h30, 8'h12);
    pulse(flag_clear);
  endtask

  // Every transmit type, reserved bits set, cleared at completion.
  task automatic tx_all();
    logic [7:0] c;
    for (int k = 0; k < 8; k++) begin
      c = 8'hc8 | 8'(k) | 8'((k % 4) * 16);
      wr(8'h51, 8'h06);
      wr(8'h52, 8'h10 + 8'(k));
      wr(8'h53, 8'hc0);
      wr(8'h50, c);
      await(tx_start, 4);
      check(outgoing_frame_kind, 16'(k));
      check(tx_retries, 16'(k % 4));
      check(tx_count_out, 16'h0006);
      check(tx_header_out, 16'hc010 + 16'(k));
      rd(8'h50, c & 8'h37);
      await(tx_done, 40);
      rd(8'h50, 8'h00);
      rd(8'h51, 8'h00);
      rd(8'h52, 8'h10 + 8'(k));
    end
  endtask

  // Reset for ten cycles, then the scenarios in turn.
  initial begin
    repeat (10) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    reset_values();
    rx_kinds();
    rx_resets();
    tx_all();
    conclude();
  end
endmodule
